// ### rtl/dac_regs_pkg.sv
// constants and carrier types for the stereo bitstream converter register block
`default_nettype none
package dac_regs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_SAMPLE0 = 8'h04;
    localparam logic [7:0] OFF_SAMPLE1 = 8'h08;
    localparam logic [7:0] OFF_LEVEL0 = 8'h0c;
    localparam logic [7:0] OFF_LEVEL1 = 8'h10;
    localparam logic [7:0] OFF_IRQ_SET = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_STATUS_CLR = 8'h24;
    localparam logic [7:0] OFF_BUILD = 8'h28;
    localparam logic [7:0] OFF_REVISION = 8'h2c;

    // control field positions
    localparam int CTL_EN = 0;
    localparam int CTL_SWAP = 1;
    localparam int CTL_ALT = 3;
    localparam int CTL_OFFSET = 4;
    localparam int CTL_MONO = 5;
    localparam int CTL_SOFT_RST = 7;
    localparam int CTL_FMT_LSB = 16;
    localparam int CTL_RATE_LSB = 24;

    // level register fields
    localparam int LVL_MUTE = 31;
    localparam logic [31:0] LVL_MASK = 32'h80007fff;

    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_SAMPLE_REQUEST_FLAG = 1;
    localparam int ST_UNDERFLOW_FLAG = 2;
    localparam logic [2:0] IRQ_BITS = 3'h6;

    // reset value of every ordinary register
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // word format codes
    localparam logic [2:0] FMT_32 = 3'h0;
    localparam logic [2:0] FMT_24 = 3'h1;
    localparam logic [2:0] FMT_20 = 3'h2;
    localparam logic [2:0] FMT_18 = 3'h3;
    localparam logic [2:0] FMT_16 = 3'h4;
    localparam logic [2:0] FMT_16C = 3'h5;
    localparam logic [2:0] FMT_8 = 3'h6;
    localparam logic [2:0] FMT_8C = 3'h7;

    // sample rate codes 0..8 are 8000..48000 Hz, the rest reserved
    localparam logic [3:0] RATE_MAX = 4'h8;

    // common-mode offset applied with halved amplitude
    localparam logic [15:0] CM_OFFSET = 16'h2000;

    // clock-domain transfer time: 8 ns at 4 ns per cycle
    localparam int XFER_NS = 8;
    localparam int CLK_NS = 4;
    localparam logic [1:0] XFER_CYCLES = 2'((XFER_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic enable;
        logic [3:0] rate;
        logic alt_ratio;
        logic offset_adjust;
    } conv_cfg_t;

    typedef struct packed {
        logic [15:0] ch1;
        logic [15:0] ch0;
    } sample_pair_t;
endpackage
`default_nettype wire

// ### rtl/stereo_bitstream_dac_regs.sv
// register interface and sample formatting of a stereo bitstream converter
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - four-bit rate field codes 0..8 pick 8000..48000 Hz, others reserved.
// - three-bit word format decodes 32,24,20,18,16,16 compact,8,8 compact.
// - 16-bit compact: ch0 from bits 15:0, ch1 from 31:16 of sample0.
// - 8-bit compact: ch0 from bits 7:0, ch1 from 15:8, rest ignored.
// - non-compact samples right-justified per register, bits above word length ignored.
// - writing one to control bit 7 resets block like hardware reset.
// - control bit 5 turns mono mode on.
// - control bit 4 turns common-mode offset adjustment on.
// - control bit 3 selects alternative upsampling ratio.
// - control bit 1 swaps the two channels.
// - control bit 0 enables the converter.
// - all registers reset to zero except build options and revision.
// - only top 16 bits of each sample used; 8-bit fills upper byte.
// - with swap, non-compact sample writes land in other register; compact writes all go to sample0, halves exchanged for sample0 writes.
// - mono feeds sample0 (channel 0 part) to both outputs.
// - busy shows during domain transfer; control/sample writes then refused.
module stereo_bitstream_dac_regs
    import dac_regs_pkg::*;
#(
    parameter logic [31:0] BUILD_OPTIONS = 32'h00000000, // arbitrary build value
    parameter logic [31:0] REVISION_INFO = 32'h00000100  // arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic sample_req_in,
    output sample_pair_t sample_out,
    output logic sample_valid_out,
    output conv_cfg_t conv_cfg_out,
    output logic busy_out,
    output logic irq_out
);

    // 16-bit sample from a right-justified word, keeping the top bits
    // low bits are dropped rather than rounded, which keeps the path plain
    function automatic logic [15:0] take16(input logic [31:0] w, input logic [2:0] f);
        logic [15:0] r;
        r = 16'h0000;
        case (f)
            FMT_32: r = w[31:16];
            FMT_24: r = w[23:8];
            FMT_20: r = w[19:4];
            FMT_18: r = w[17:2];
            FMT_16, FMT_16C: r = w[15:0];
            FMT_8, FMT_8C: r = {w[7:0], 8'h00};
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // channel 1 part of a compact sample0 word
    function automatic logic [15:0] upper16(input logic [31:0] w, input logic [2:0] f);
        logic [15:0] r;
        r = (f == FMT_8C) ? {w[15:8], 8'h00} : w[31:16];
        return r;
    endfunction

    // exchange the two channel parts of a compact word
    // the upper half of an 8-bit compact word is cleared since it is ignored
    function automatic logic [31:0] swap_halves(input logic [31:0] w, input logic [2:0] f);
        logic [31:0] r;
        r = (f == FMT_8C) ? {16'h0000, w[7:0], w[15:8]} : {w[15:0], w[31:16]};
        return r;
    endfunction

    // common-mode shift: halve amplitude and push the channels apart
    // halving first keeps the sum inside sixteen bits at the cost of one bit
    function automatic logic [15:0] cm_adjust(input logic [15:0] s, input logic up);
        logic [15:0] h;
        h = {s[15], s[15:1]};
        return up ? (h + CM_OFFSET) : (h - CM_OFFSET);
    endfunction

    // reset pulse from software and the reset that every other register obeys
    logic soft_rst_q;
    logic rst;

    // register contents as software sees them
    logic [31:0] ctrl_q;
    logic [31:0] smp0_q;
    logic [31:0] smp1_q;
    logic [31:0] lvl0_q;
    logic [31:0] lvl1_q;

    // interrupt mask and sticky flags; bit 0 of the flags stays unused
    logic [2:0] mask_q;
    logic [2:0] status_q;

    // transfer timer and which sample words were written since the last take
    logic [1:0] busy_cnt_q;
    logic fresh0_q;
    logic fresh1_q;

    // flops behind the top-level outputs
    logic [31:0] rdata_q;
    logic irq_q;
    sample_pair_t sample_q;
    logic valid_q;

    // decoded control fields and the busy flag
    logic [2:0] fmt;
    logic compact;
    logic busy;

    // bus write qualifiers after the busy check
    logic wr_ok;
    logic wr_ctl;
    logic wr_s0;
    logic wr_s1;

    // sample writes after channel steering
    logic [31:0] s0_word;
    logic [31:0] s1_word;
    logic s0_hit;
    logic s1_hit;

    // converter request, flag events and the pair it would receive
    logic fresh;
    logic take;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    sample_pair_t pair;

    assign fmt = ctrl_q[CTL_FMT_LSB +: 3];
    assign compact = (fmt == FMT_16C) || (fmt == FMT_8C);
    assign busy = (busy_cnt_q != 2'h0);

    // software reset acts one cycle after the write, like the pin
    assign rst = srst_in | soft_rst_q;

    // writes to control and sample words are refused until the transfer finishes
    assign wr_ok = reg_wr_in && !busy;
    assign wr_ctl = wr_ok && (reg_addr_in == OFF_CONTROL);
    assign wr_s0 = wr_ok && (reg_addr_in == OFF_SAMPLE0);
    assign wr_s1 = wr_ok && (reg_addr_in == OFF_SAMPLE1);

    // steering of sample writes under swap
    always_comb begin
        s0_hit = 1'b0;
        s1_hit = 1'b0;
        s0_word = reg_wdata_in;
        s1_word = reg_wdata_in;
        if (ctrl_q[CTL_SWAP] && compact) begin
            s0_hit = wr_s0 || wr_s1;
            s0_word = wr_s0 ? swap_halves(reg_wdata_in, fmt) : reg_wdata_in;
        end else if (ctrl_q[CTL_SWAP]) begin
            s0_hit = wr_s1;
            s1_hit = wr_s0;
        end else begin
            s0_hit = wr_s0;
            s1_hit = wr_s1;
        end
    end

    // a new pair is complete once every used register was written
    // mono and compact modes never wait for the second word
    assign fresh = fresh0_q && (fresh1_q || compact || ctrl_q[CTL_MONO]);
    assign take = sample_req_in && ctrl_q[CTL_EN];

    // formatting of the outgoing pair
    always_comb begin
        pair.ch0 = take16(smp0_q, fmt);
        pair.ch1 = compact ? upper16(smp0_q, fmt) : take16(smp1_q, fmt);
        if (ctrl_q[CTL_MONO]) begin
            pair.ch1 = pair.ch0;
        end
        if (ctrl_q[CTL_OFFSET]) begin
            pair.ch0 = cm_adjust(pair.ch0, 1'b1);
            pair.ch1 = cm_adjust(pair.ch1, 1'b0);
        end
        // mute comes last so a muted channel is silent even with the offset on
        if (lvl0_q[LVL_MUTE]) begin
            pair.ch0 = 16'h0000;
        end
        if (lvl1_q[LVL_MUTE]) begin
            pair.ch1 = 16'h0000;
        end
    end

    // status events and their clears
    always_comb begin
        ev_set = 3'h0;
        ev_set[ST_SAMPLE_REQUEST_FLAG] = take;
        ev_set[ST_UNDERFLOW_FLAG] = take && !fresh;
        ev_clr = 3'h0;
        if (reg_wr_in && reg_addr_in == OFF_STATUS_CLR) begin
            ev_clr = reg_wdata_in[2:0] & IRQ_BITS;
        end
        if (reg_rd_in && reg_addr_in == OFF_STATUS) begin
            ev_clr = IRQ_BITS;
        end
    end

    // soft reset pulse; only the pin clears it so it cannot hold itself
    // a soft reset write while busy is refused like any control write
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            soft_rst_q <= 1'b0;
        end else if (clk_en_in) begin
            soft_rst_q <= wr_ctl && reg_wdata_in[CTL_SOFT_RST];
        end
    end

    // control register; the reset bit is never stored
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            ctrl_q <= REG_RESET;
        end else if (clk_en_in && wr_ctl && !reg_wdata_in[CTL_SOFT_RST]) begin
            ctrl_q <= reg_wdata_in & 32'h0f07003b;
        end
    end

    // sample words
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            smp0_q <= REG_RESET;
            smp1_q <= REG_RESET;
        end else if (clk_en_in) begin
            if (s0_hit) begin
                smp0_q <= s0_word;
            end
            if (s1_hit) begin
                smp1_q <= s1_word;
            end
        end
    end

    // freshness of the sample words; a write beside a take counts for the next
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            fresh0_q <= 1'b0;
            fresh1_q <= 1'b0;
        end else if (clk_en_in) begin
            fresh0_q <= s0_hit || (fresh0_q && !take);
            fresh1_q <= s1_hit || (fresh1_q && !take);
        end
    end

    // level registers hold mute and volume for the filter stage
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            lvl0_q <= REG_RESET;
            lvl1_q <= REG_RESET;
        end else if (clk_en_in && reg_wr_in) begin
            if (reg_addr_in == OFF_LEVEL0) begin
                lvl0_q <= reg_wdata_in & LVL_MASK;
            end
            if (reg_addr_in == OFF_LEVEL1) begin
                lvl1_q <= reg_wdata_in & LVL_MASK;
            end
        end
    end

    // transfer timer started by each accepted control or sample write
    // limitation: a refused write leaves no trace, software must poll busy
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            busy_cnt_q <= 2'h0;
        end else if (clk_en_in) begin
            if (wr_ctl || wr_s0 || wr_s1) begin
                busy_cnt_q <= XFER_CYCLES;
            end else if (busy) begin
                busy_cnt_q <= busy_cnt_q - 2'h1;
            end
        end
    end

    // interrupt mask set and clear; set wins if both touch a bit
    // set and clear use separate offsets, so they never meet in one cycle
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            mask_q <= 3'h0;
        end else if (clk_en_in && reg_wr_in) begin
            if (reg_addr_in == OFF_IRQ_CLR) begin
                mask_q <= mask_q & ~(reg_wdata_in[2:0] & IRQ_BITS);
            end
            if (reg_addr_in == OFF_IRQ_SET) begin
                mask_q <= mask_q | (reg_wdata_in[2:0] & IRQ_BITS);
            end
        end
    end

    // sticky flags: an event in the clearing cycle survives
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            status_q <= 3'h0;
        end else if (clk_en_in) begin
            status_q <= (status_q & ~ev_clr) | ev_set;
        end
    end

    // pair handed to the converter on each enabled request
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            sample_q <= '0;
            valid_q <= 1'b0;
        end else if (clk_en_in) begin
            valid_q <= take;
            if (take) begin
                sample_q <= pair;
            end
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    // only the status read has a side effect: it clears the sticky flags
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            rdata_q <= REG_RESET;
        end else if (clk_en_in) begin
            rdata_q <= 32'h00000000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    OFF_CONTROL: rdata_q <= ctrl_q;
                    OFF_SAMPLE0: rdata_q <= smp0_q;
                    OFF_SAMPLE1: rdata_q <= smp1_q;
                    OFF_LEVEL0: rdata_q <= lvl0_q;
                    OFF_LEVEL1: rdata_q <= lvl1_q;
                    OFF_IRQ_MASK: rdata_q <= {29'h0, mask_q};
                    OFF_STATUS: rdata_q <= {29'h0, status_q[2:1], busy};
                    OFF_BUILD: rdata_q <= BUILD_OPTIONS;
                    OFF_REVISION: rdata_q <= REVISION_INFO;
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // level interrupt from unmasked sticky flags
    // one cycle of lag keeps the output straight off a flop
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (clk_en_in) begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // converter settings; clock choice for the alt ratio is the system's job
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            conv_cfg_out <= '0;
            busy_out <= 1'b0;
        end else if (clk_en_in) begin
            conv_cfg_out.enable <= ctrl_q[CTL_EN];
            conv_cfg_out.rate <= ctrl_q[CTL_RATE_LSB +: 4];
            conv_cfg_out.alt_ratio <= ctrl_q[CTL_ALT];
            conv_cfg_out.offset_adjust <= ctrl_q[CTL_OFFSET];
            busy_out <= busy;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out = irq_q;
    assign sample_out = sample_q;
    assign sample_valid_out = valid_q;

endmodule

`default_nettype wire

// ### verification/converter_model.sv
// converter-side model that pulls formatted sample pairs from the block
`timescale 1ns/100ps
`default_nettype none
module converter_model
    import dac_regs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sample_valid_in,
    input wire sample_pair_t sample_in,
    output logic sample_req_out
);
    initial sample_req_out = 1'b0;
    // one request pulse per pull; the answer stands only in the next cycle
    task automatic pull(output sample_pair_t s, output logic got);
        @(posedge core_clk_in);
        sample_req_out <= 1'b1;
        @(posedge core_clk_in);
        sample_req_out <= 1'b0;
        #1;
        got = sample_valid_in;
        s = sample_in;
    endtask
endmodule
`default_nettype wire

// ### verification/stereo_bitstream_dac_regs_asserts.sv
// port-level assertions for the converter register block
`timescale 1ns/100ps
`default_nettype none
module stereo_bitstream_dac_regs_asserts
    import dac_regs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic sample_req_in,
    input wire sample_pair_t sample_out,
    input wire logic sample_valid_out,
    input wire conv_cfg_t conv_cfg_out,
    input wire logic busy_out,
    input wire logic irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // decoded bus events; with the clock enable low nothing is taken
    wire logic wr_go = reg_wr_in && clk_en_in;
    wire logic rd_go = reg_rd_in && clk_en_in;
    wire logic ctl_hit = wr_go && reg_addr_in == OFF_CONTROL;
    wire logic soft_wr = ctl_hit && reg_wdata_in[CTL_SOFT_RST];
    wire logic cfg_wr = ctl_hit && !reg_wdata_in[CTL_SOFT_RST];
    wire logic smp_wr = wr_go && (reg_addr_in == OFF_SAMPLE0 || reg_addr_in == OFF_SAMPLE1);
    wire logic data_wr = cfg_wr || smp_wr;
    wire logic wo_addr = reg_addr_in == OFF_IRQ_SET || reg_addr_in == OFF_IRQ_CLR
        || reg_addr_in == OFF_STATUS_CLR;
    wire logic odd_rd = rd_go && (reg_addr_in > OFF_REVISION || wo_addr);

    property p_rdata_idle;
        (clk_en_in && !reg_rd_in) |=> reg_rdata_out == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data nonzero outside a read answer");
    property p_unmapped_rd;
        odd_rd |=> reg_rdata_out == 32'h0;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd)
        else $error("unmapped or write-only read returned data");
    property p_valid_cause;
        sample_valid_out |-> $past(sample_req_in);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("sample valid without a request");
    // a write refused in the first busy cycle lands inside the same busy span, so this holds for it; one in the second does not
    property p_busy_start;
        data_wr |-> ##2 busy_out;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy missing after a control or sample write");
    property p_busy_len;
        $rose(busy_out) |=> busy_out ##1 !busy_out;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy span is not two cycles");
    property p_cfg_copy;
        logic [31:0] d;
        (cfg_wr, d = reg_wdata_in) |-> ##2 conv_cfg_out ==
            {d[CTL_EN], d[CTL_RATE_LSB +: 4], d[CTL_ALT], d[CTL_OFFSET]};
    endproperty
    a_cfg_copy: assert property (p_cfg_copy)
        else $error("converter config does not follow control write");
    property p_soft_reset;
        soft_wr |-> ##3 (conv_cfg_out == 7'h00 && !busy_out && sample_out == 32'h0);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not clear the block");
    property p_hw_reset;
        $fell(srst_in) |-> (conv_cfg_out == 7'h00 && !busy_out && !irq_out
            && !sample_valid_out && reg_rdata_out == 32'h0);
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("outputs not zero after reset");
    c_soft: cover property (soft_wr);
    c_take: cover property (sample_valid_out);
    c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

// ### verification/stereo_bitstream_dac_regs_bench.sv
// self-checking bench for the converter register block
`timescale 1ns/100ps
`default_nettype none
module stereo_bitstream_dac_regs_bench
    import dac_regs_pkg::*;
;
    localparam logic [31:0] BUILD_VAL = 32'h000000c3; // arbitrary
    localparam logic [31:0] REV_VAL = 32'h00000a51; // arbitrary
    localparam logic [31:0] WA = 32'h12345678;
    localparam logic [31:0] WB = 32'h9abcdef0;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic sample_req;
    sample_pair_t sample;
    logic valid;
    conv_cfg_t cfg;
    logic busy;
    logic irq;
    int miscompares = 0;
    int tests_run = 0;

    always #2 core_clk = ~core_clk;

    stereo_bitstream_dac_regs #(.BUILD_OPTIONS(BUILD_VAL), .REVISION_INFO(REV_VAL)) dut (
        .core_clk_in(core_clk), .srst_in(srst), .clk_en_in(clk_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .sample_req_in(sample_req), .sample_out(sample), .sample_valid_out(valid),
        .conv_cfg_out(cfg), .busy_out(busy), .irq_out(irq));
    converter_model conv (.core_clk_in(core_clk), .sample_valid_in(valid),
        .sample_in(sample), .sample_req_out(sample_req));

    // expected pair from the word format, worked out independently
    function automatic logic [31:0] exp_pair(input logic [2:0] f, input logic [31:0] a,
        input logic [31:0] b);
        case (f)
            FMT_32: return {b[31:16], a[31:16]};
            FMT_24: return {b[23:8], a[23:8]};
            FMT_20: return {b[19:4], a[19:4]};
            FMT_18: return {b[17:2], a[17:2]};
            FMT_16: return {b[15:0], a[15:0]};
            FMT_16C: return a;
            FMT_8: return {b[7:0], 8'h00, a[7:0], 8'h00};
            default: return {a[15:8], 8'h00, a[7:0], 8'h00};
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // idle cycles after each write keep clear of the busy span
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask
    task automatic take(input logic [31:0] exp);
        sample_pair_t s;
        logic g;
        conv.pull(s, g);
        chk("sample valid", 32'h1, 32'(g));
        chk("sample pair", exp, s);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 12; i++) begin
            rchk(8'(i * 4), i == 10 ? BUILD_VAL : (i == 11 ? REV_VAL : 32'h0));
        end
        rchk(8'h30, 32'h0);
        wr_reg(8'h30, 32'hffffffff);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr_reg(OFF_CONTROL, 32'h00040001);
        clk_en <= 1'b1;
        rchk(OFF_CONTROL, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_formats();
        for (int f = 0; f < 8; f++) begin
            wr_reg(OFF_CONTROL, {4'h0, 4'(f), 5'h00, 3'(f), 16'h0001});
            wr_reg(OFF_SAMPLE0, WA ^ 32'(f));
            if (f != 5 && f != 7) begin
                wr_reg(OFF_SAMPLE1, WB);
            end
            take(exp_pair(3'(f), WA ^ 32'(f), WB));
        end
        $display("test formats done");
    endtask
    task automatic t_swap_mono();
        wr_reg(OFF_CONTROL, 32'h00040003);
        wr_reg(OFF_SAMPLE0, WA);
        wr_reg(OFF_SAMPLE1, WB);
        rchk(OFF_SAMPLE1, WA);
        take({WA[15:0], WB[15:0]});
        wr_reg(OFF_CONTROL, 32'h00050003);
        wr_reg(OFF_SAMPLE0, WA);
        take({WA[15:0], WA[31:16]});
        wr_reg(OFF_CONTROL, 32'h00040021);
        wr_reg(OFF_SAMPLE0, WB);
        take({WB[15:0], WB[15:0]});
        wr_reg(OFF_CONTROL, 32'h00050021);
        wr_reg(OFF_SAMPLE0, WA);
        take({WA[15:0], WA[15:0]});
        $display("test swap and mono done");
    endtask
    task automatic t_offset();
        wr_reg(OFF_CONTROL, 32'h07040019);
        wr_reg(OFF_SAMPLE0, 32'h00004000);
        wr_reg(OFF_SAMPLE1, 32'h00008000);
        take(32'ha0004000);
        chk("converter config", 32'h5f, 32'(cfg));
        wr_reg(OFF_LEVEL1, 32'hffffffff);
        rchk(OFF_LEVEL1, LVL_MASK);
        take(32'h00004000);
        wr_reg(OFF_LEVEL1, 32'h00000000);
        $display("test offset done");
    endtask
    // second write lands inside the busy span and must be dropped
    task automatic t_busy();
        wr_reg(OFF_CONTROL, 32'h00040001);
        @(posedge core_clk);
        addr <= OFF_SAMPLE0;
        wdata <= WA;
        wr <= 1'b1;
        @(posedge core_clk);
        wdata <= WB;
        @(posedge core_clk);
        wr <= 1'b0;
        addr <= OFF_STATUS;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk("busy bit", 32'h1, 32'(rdata[ST_BUSY]));
        chk("busy out", 32'h1, 32'(busy));
        rchk(OFF_SAMPLE0, WA);
        $display("test busy done");
    endtask
    task automatic t_irq();
        rchk(OFF_STATUS, 32'h0);
        wr_reg(OFF_IRQ_SET, 32'h00000006);
        rchk(OFF_IRQ_MASK, 32'h6);
        wr_reg(OFF_SAMPLE1, WB);
        take(exp_pair(FMT_16, WA, WB));
        repeat (2) @(posedge core_clk);
        chk("irq on ready", 32'h1, 32'(irq));
        rchk(OFF_STATUS, 32'h2);
        repeat (2) @(posedge core_clk);
        chk("irq after read", 32'h0, 32'(irq));
        take(exp_pair(FMT_16, WA, WB));
        rchk(OFF_STATUS, 32'h6);
        take(exp_pair(FMT_16, WA, WB));
        wr_reg(OFF_IRQ_CLR, 32'h00000006);
        chk("irq masked", 32'h0, 32'(irq));
        rchk(OFF_IRQ_MASK, 32'h0);
        wr_reg(OFF_STATUS_CLR, 32'h00000006);
        rchk(OFF_STATUS, 32'h0);
        $display("test interrupt done");
    endtask
    task automatic t_soft();
        sample_pair_t s;
        logic g;
        wr_reg(OFF_CONTROL, 32'h00040002);
        rchk(OFF_CONTROL, 32'h00040002);
        conv.pull(s, g);
        chk("take while disabled", 32'h0, 32'(g));
        wr_reg(OFF_CONTROL, 32'h00000080);
        rchk(OFF_CONTROL, 32'h0);
        rchk(OFF_SAMPLE0, 32'h0);
        $display("test soft reset done");
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_formats();
        t_swap_mono();
        t_offset();
        t_busy();
        t_irq();
        t_soft();
        stop_test();
    end
    // a few hundred cycles are needed; this cuts a hang short
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule
bind stereo_bitstream_dac_regs stereo_bitstream_dac_regs_asserts chk_i (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sample_req_in(sample_req_in),
    .sample_out(sample_out), .sample_valid_out(sample_valid_out),
    .conv_cfg_out(conv_cfg_out), .busy_out(busy_out), .irq_out(irq_out));
`default_nettype wire
